// ===== rtl/adc_aux_params.svh
// constants for the auxiliary digital functions block
// assumes a 40 MHz system clock and the mode register layout given below
`ifndef ADC_AUX_PARAMS_SVH
`define ADC_AUX_PARAMS_SVH

`define CLK_PERIOD_NS        25
`define CLK_FREQ_MHZ         40
`define MODE_REG_OFFSET      8'h01
`define MODE_REG_RESET       16'h0000
`define MODE_DELAY_LSB       8
`define MODE_DELAY_MSB       10
`define CRC_POLY             8'h07
`define FAULT_FUNC_GP_OUT    2'b11
`define DOUT_REVERT_NS       10
`define DOUT_REVERT_CYCLES   ((`DOUT_REVERT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DELAY_US_0           0
`define DELAY_US_1           4
`define DELAY_US_2           16
`define DELAY_US_3           40
`define DELAY_US_4           100
`define DELAY_US_5           200
`define DELAY_US_6           500
`define DELAY_US_7           1000

`endif

// ===== rtl/adc_aux_pkg.sv
// types shared by the auxiliary digital functions block
// no surroundings assumed
package adc_aux_pkg;
   typedef enum logic [1:0] {
      CONV_IDLE  = 2'b00,
      CONV_HOLD  = 2'b01,
      CONV_DELAY = 2'b10,
      CONV_RUN   = 2'b11
   } conv_state_t;

   typedef enum logic [1:0] {
      DOUT_READY  = 2'b00,
      DOUT_DATA   = 2'b01,
      DOUT_REVERT = 2'b10
   } dout_state_t;
endpackage

// ===== rtl/adc_aux_functions.sv
// auxiliary digital functions of a sigma-delta converter's control logic
// assumes control bits come from the serial register file as plain levels
//
// What this block does
// [R01] polynomial checksum: remainder of message times 2^8 divided by 100000111
// [R02] xor checksum: xor of all message bytes gives eight bits
// [R03] two aux pins, each enabled as input or output by its own bit
// [R04] aux pin as input: level shows in its level bit
// [R05] aux pin as output: pin driven to its level bit
// [R06] fault function 11 with sync select clear: shared pin is an output following fault pin level
// [R07] external mux timing: aux outputs change only at conversion start
// [R08] mode register bits 10:8 pick one of eight delays, zero to 1 ms
// [R09] nonzero delay without hiding lengthens each conversion by the delay
// [R10] hidden delay under half conversion keeps conversion time, fewer averages
// [R11] hiding only below 100 kSPS, four listed rates absorb nothing
// [R12] results 24 bits, or rounded to 16 bits with short width set
// [R13] data-out pin: ready when idle, data in read, ready shortly after
// [R14] data-out reset set: read data held until chip select rises
// [R15] sync select: shared pin resets modulator and filter, setup kept
// [R16] controller holds sync low at least one master clock period
// [R17] sync falling edge resets filter, held while sync stays low
// [R18] after sync rises, device leaves reset next edge and samples
// [R19] several devices: controller raises sync on a master clock edge
// [R20] single channel: sync rise starts conversion, ready falls when settled
// [R21] controller drives sync low before next conversion start
// [R22] write checksum covers command byte then eight to 24 data bits
// [R23] aux inputs and sync pass a two-stage synchroniser
`timescale 1ns/1ps
`include "adc_aux_params.svh"
module adc_aux_functions
   import adc_aux_pkg::*;
#(
   parameter int unsigned US_CYCLES = `CLK_FREQ_MHZ
) (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // register contents
   input  wire logic [15:0] i_converter_mode_control,
   input  wire logic        i_aux0_input_enable,
   input  wire logic        i_aux1_input_enable,
   input  wire logic        i_aux0_output_enable,
   input  wire logic        i_aux1_output_enable,
   input  wire logic        i_aux0_level_bit,
   input  wire logic        i_aux1_level_bit,
   input  wire logic [1:0]  i_fault_func,
   input  wire logic        i_fault_pin_level,
   input  wire logic        i_sync_select,
   input  wire logic        i_external_mux_timing,
   input  wire logic        i_short_result_width,
   input  wire logic        i_dout_reset,
   input  wire logic        i_hide_delay,
   input  wire logic        i_sinc_combined,
   input  wire logic [23:0] i_rate_sps,
   input  wire logic [23:0] i_conv_cycles,
   // conversion core
   input  wire logic        i_conv_start,
   input  wire logic [23:0] i_raw_result,
   // checksum request
   input  wire logic        i_crc_go,
   input  wire logic        i_crc_use_xor,
   input  wire logic [31:0] i_crc_msg,
   input  wire logic [2:0]  i_crc_bytes,
   // serial read path
   input  wire logic        i_cs_n,
   input  wire logic        i_read_active,
   input  wire logic        i_read_bit,
   input  wire logic        i_read_done,
   // pins
   input  wire logic [1:0]  i_aux_pin,
   input  wire logic        i_sync_fault_pin,
   output logic [1:0]       o_aux_pin_out,
   output logic [1:0]       o_aux_pin_oe,
   output logic             o_sync_fault_out,
   output logic             o_sync_fault_oe,
   output logic             o_dout_rdy_n,
   // status back to the register file
   output logic [1:0]       o_aux_level_read,
   output logic             o_filter_reset,
   output logic             o_avg_trimmed,
   output logic [23:0]      o_result,
   output logic             o_result_valid,
   output logic [7:0]       o_checksum,
   output logic             o_checksum_valid
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronisers and pin directions
   logic [1:0] aux_meta_reg, aux_sync_reg, in_en, out_en, level_bits;
   logic [1:0] aux_out_reg, aux_out_next, aux_read_reg, aux_read_next;
   logic       sync_meta_reg, sync_reg, sync_prev_reg;
   assign in_en      = {i_aux1_input_enable, i_aux0_input_enable};
   assign out_en     = {i_aux1_output_enable, i_aux0_output_enable};
   assign level_bits = {i_aux1_level_bit, i_aux0_level_bit};
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_aux
         always_ff @(posedge i_clk_sys or posedge i_reset) begin
            if (i_reset) begin
               aux_meta_reg[g] <= 1'b0;
               aux_sync_reg[g] <= 1'b0;
            end else begin
               aux_meta_reg[g] <= i_aux_pin[g];        // [R23]
               aux_sync_reg[g] <= aux_meta_reg[g];     // [R23]
            end
         end
      end
   endgenerate
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         sync_meta_reg <= 1'b1;
         sync_reg      <= 1'b1;
         sync_prev_reg <= 1'b1;
      end else begin
         sync_meta_reg <= i_sync_fault_pin;            // [R23]
         sync_reg      <= sync_meta_reg;               // [R23]
         sync_prev_reg <= sync_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencing: sync hold, pre-sample delay, run
   conv_state_t conv_state_reg, conv_state_next;
   logic [31:0] count_reg, count_next, delay_cycles, conv_len;
   logic [9:0]  delay_us;
   logic        rate_ok, hide_ok, trimmed_reg, trimmed_next, sync_fall, sync_rise, start;
   logic [23:0] result_reg, result_next;
   logic        valid_reg, valid_next, rdy_reg, rdy_next;
   logic [16:0] rounded;
   always_comb begin
      unique case (i_converter_mode_control[`MODE_DELAY_MSB:`MODE_DELAY_LSB])   // [R08]
         3'd0: delay_us = 10'(`DELAY_US_0);
         3'd1: delay_us = 10'(`DELAY_US_1);
         3'd2: delay_us = 10'(`DELAY_US_2);
         3'd3: delay_us = 10'(`DELAY_US_3);
         3'd4: delay_us = 10'(`DELAY_US_4);
         3'd5: delay_us = 10'(`DELAY_US_5);
         3'd6: delay_us = 10'(`DELAY_US_6);
         3'd7: delay_us = 10'(`DELAY_US_7);
      endcase
   end
   assign delay_cycles = 32'(delay_us) * US_CYCLES;
   assign rate_ok = (i_rate_sps < 24'd100000) && (i_rate_sps != 24'd3975) && (i_rate_sps != 24'd599)
                    && (i_rate_sps != 24'd500) && (i_rate_sps != 24'd167);          // [R11]
   assign hide_ok = i_hide_delay && i_sinc_combined && rate_ok
                    && ((delay_cycles << 1) < 32'(i_conv_cycles));                  // [R10]
   assign conv_len = hide_ok ? 32'(i_conv_cycles) - delay_cycles : 32'(i_conv_cycles);   // [R09] [R10]
   assign sync_fall = i_sync_select && sync_prev_reg && !sync_reg;                  // [R15]
   assign sync_rise = i_sync_select && !sync_prev_reg && sync_reg;
   assign start     = i_conv_start || sync_rise;                                    // [R20]
   assign rounded   = (&i_raw_result[23:8]) ? {1'b0, i_raw_result[23:8]}
                      : 17'(i_raw_result[23:8]) + 17'(i_raw_result[7]);             // [R12]
   always_comb begin
      conv_state_next = conv_state_reg;
      count_next      = count_reg;
      trimmed_next    = trimmed_reg;
      result_next     = result_reg;
      valid_next      = 1'b0;
      rdy_next        = rdy_reg;
      if (i_read_done) begin
         rdy_next = 1'b1;
      end
      if (sync_fall || (i_sync_select && !sync_reg)) begin
         conv_state_next = CONV_HOLD;                                               // [R17]
         rdy_next        = 1'b1;
      end else begin
         unique case (conv_state_reg)
            CONV_IDLE, CONV_HOLD: begin
               if (start || conv_state_reg == CONV_HOLD) begin                      // [R18]
                  conv_state_next = (delay_cycles != 32'd0) ? CONV_DELAY : CONV_RUN;   // [R09] [R10]
                  count_next      = (delay_cycles != 32'd0) ? delay_cycles : conv_len;
                  trimmed_next    = hide_ok && delay_cycles != 32'd0;
                  rdy_next        = 1'b1;
               end
            end
            CONV_DELAY: begin
               if (count_reg <= 32'd1) begin
                  conv_state_next = CONV_RUN;                                       // [R09]
                  count_next      = conv_len;
               end else begin
                  count_next = count_reg - 32'd1;
               end
            end
            CONV_RUN: begin
               if (count_reg <= 32'd1) begin
                  conv_state_next = CONV_IDLE;
                  result_next     = i_short_result_width ? {8'h00, rounded[15:0]} : i_raw_result;   // [R12]
                  valid_next      = 1'b1;
                  rdy_next        = 1'b0;                                           // [R20]
               end else begin
                  count_next = count_reg - 32'd1;
               end
            end
         endcase
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         conv_state_reg <= CONV_IDLE;
         count_reg      <= 32'h0000_0000;
         trimmed_reg    <= 1'b0;
         result_reg     <= 24'h00_0000;
         valid_reg      <= 1'b0;
         rdy_reg        <= 1'b1;
      end else begin
         conv_state_reg <= conv_state_next;
         count_reg      <= count_next;
         trimmed_reg    <= trimmed_next;
         result_reg     <= result_next;
         valid_reg      <= valid_next;
         rdy_reg        <= rdy_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // aux and shared pin outputs
   logic sf_out_reg, sf_oe_reg, filt_reg, conv_begin;
   assign conv_begin = (conv_state_reg == CONV_IDLE || conv_state_reg == CONV_HOLD)
                       && (conv_state_next == CONV_DELAY || conv_state_next == CONV_RUN);
   always_comb begin
      aux_out_next  = aux_out_reg;
      aux_read_next = aux_read_reg;
      if (!i_external_mux_timing || conv_begin) begin
         aux_out_next = level_bits;                                                 // [R05] [R07]
      end
      for (int i = 0; i < 2; i++) begin
         if (in_en[i]) begin
            aux_read_next[i] = aux_sync_reg[i];                                     // [R04]
         end else begin
            aux_read_next[i] = level_bits[i];
         end
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         aux_out_reg  <= 2'b00;
         aux_read_reg <= 2'b00;
         o_aux_pin_oe <= 2'b00;
         sf_out_reg   <= 1'b0;
         sf_oe_reg    <= 1'b0;
         filt_reg     <= 1'b0;
      end else begin
         aux_out_reg  <= aux_out_next;
         aux_read_reg <= aux_read_next;
         o_aux_pin_oe <= out_en & ~in_en;                                           // [R03]
         sf_out_reg   <= i_fault_pin_level;                                         // [R06]
         sf_oe_reg    <= !i_sync_select && (i_fault_func == `FAULT_FUNC_GP_OUT);    // [R06]
         filt_reg     <= conv_state_next == CONV_HOLD;                              // [R15] [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data-out / ready pin
   dout_state_t dout_state_reg, dout_state_next;
   logic [7:0]  revert_reg, revert_next;
   logic        dout_reg, dout_next;
   always_comb begin
      dout_state_next = dout_state_reg;
      revert_next     = revert_reg;
      dout_next       = dout_reg;
      unique case (dout_state_reg)
         DOUT_READY: begin
            dout_next = rdy_next || i_cs_n;                                         // [R13]
            if (i_read_active) begin
               dout_state_next = DOUT_DATA;
               dout_next       = i_read_bit;
            end
         end
         DOUT_DATA: begin
            if (i_read_active) begin
               dout_next = i_read_bit;                                              // [R13]
            end else begin
               dout_state_next = DOUT_REVERT;
               revert_next     = 8'(`DOUT_REVERT_CYCLES);
            end
         end
         DOUT_REVERT: begin
            if (i_dout_reset ? i_cs_n : (revert_reg <= 8'd1)) begin                 // [R13] [R14]
               dout_state_next = DOUT_READY;
               dout_next       = rdy_next || i_cs_n;
            end else begin
               revert_next = revert_reg - 8'd1;
            end
         end
         default: begin
            dout_state_next = DOUT_READY;
         end
      endcase
   end
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         dout_state_reg <= DOUT_READY;
         revert_reg     <= 8'h00;
         dout_reg       <= 1'b1;
      end else begin
         dout_state_reg <= dout_state_next;
         revert_reg     <= revert_next;
         dout_reg       <= dout_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checksum: command byte first, message msb-aligned in i_crc_msg
   function automatic logic [7:0] crc_of(input logic [31:0] msg, input logic [2:0] nbytes);
      logic [7:0] c;
      c = 8'h00;
      for (int b = 31; b >= 0; b--) begin
         if (b >= 32 - 8 * int'(nbytes)) c = {c[6:0], 1'b0} ^ ((c[7] ^ msg[b]) ? `CRC_POLY : 8'h00);   // [R01]
      end
      return c;
   endfunction
   function automatic logic [7:0] xor_of(input logic [31:0] msg, input logic [2:0] nbytes);
      logic [7:0] x;
      x = 8'h00;
      for (int k = 0; k < 4; k++) begin
         if (k < int'(nbytes)) x = x ^ msg[31 - 8 * k -: 8];                         // [R02]
      end
      return x;
   endfunction
   logic [7:0] sum_reg, sum_next;
   logic       sum_valid_reg;
   always_comb begin
      sum_next = sum_reg;
      if (i_crc_go) begin
         sum_next = i_crc_use_xor ? xor_of(i_crc_msg, i_crc_bytes) : crc_of(i_crc_msg, i_crc_bytes);   // [R22]
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         sum_reg       <= 8'h00;
         sum_valid_reg <= 1'b0;
      end else begin
         sum_reg       <= sum_next;
         sum_valid_reg <= i_crc_go;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops
   assign {o_aux_pin_out, o_aux_level_read, o_sync_fault_out, o_sync_fault_oe, o_dout_rdy_n, o_filter_reset} =
          {aux_out_reg, aux_read_reg, sf_out_reg, sf_oe_reg, dout_reg, filt_reg};
   assign {o_avg_trimmed, o_result, o_result_valid, o_checksum, o_checksum_valid} =
          {trimmed_reg, result_reg, valid_reg, sum_reg, sum_valid_reg};
endmodule

// ===== test/adc_aux_functions_sva.sv
// concurrent checks on the auxiliary function block ports
// assumes it is bound into adc_aux_functions, one clock domain
`timescale 1ns/1ps
module adc_aux_functions_chk (
   // clock and reset
   input wire logic        i_clk_sys, i_reset,
   // controls, pins in and aux pin outputs
   input wire logic        i_aux0_input_enable, i_aux0_output_enable, i_aux0_level_bit, i_external_mux_timing,
   input wire logic [1:0]  i_fault_func,
   input wire logic        i_fault_pin_level, i_sync_select, i_short_result_width, i_dout_reset, i_crc_go,
   input wire logic        i_cs_n, i_read_active, i_read_bit, i_sync_fault_pin,
   input wire logic [1:0]  i_aux_pin, o_aux_pin_out, o_aux_pin_oe, o_aux_level_read,
   // outputs
   input wire logic        o_sync_fault_out, o_sync_fault_oe, o_dout_rdy_n, o_filter_reset,
   input wire logic        o_result_valid, o_checksum_valid,
   input wire logic [23:0] o_result,
   input wire logic [7:0]  o_checksum
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   AST_CRC_ANSWER: assert property (i_crc_go |=> o_checksum_valid)
      else $error("checksum valid missing");
   AST_CRC_CAUSE: assert property (o_checksum_valid |-> $past(i_crc_go))
      else $error("checksum valid without request");
   AST_CRC_STANDS: assert property (!i_crc_go |=> $stable(o_checksum))
      else $error("checksum changed without request");
   AST_AUX_OUT: assert property (i_aux0_output_enable && !i_aux0_input_enable && !i_external_mux_timing
      |=> o_aux_pin_oe[0] && o_aux_pin_out[0] == $past(i_aux0_level_bit)) else $error("aux output wrong");
   AST_AUX_NO_DRIVE: assert property (i_aux0_input_enable |=> !o_aux_pin_oe[0])
      else $error("aux input driven");
   AST_AUX_IN: assert property ((i_aux0_input_enable && $stable(i_aux_pin[0]))[*4]
      |-> o_aux_level_read[0] == i_aux_pin[0]) else $error("aux readback wrong");
   AST_FAULT_GPO: assert property (i_fault_func == 2'b11 && !i_sync_select
      |=> o_sync_fault_oe && o_sync_fault_out == $past(i_fault_pin_level)) else $error("shared pin output wrong");
   AST_SYNC_HOLD: assert property ((i_sync_select && !i_sync_fault_pin)[*4] |-> o_filter_reset)
      else $error("filter not held in reset");
   AST_SYNC_NO_RESULT: assert property (o_filter_reset |-> !o_result_valid)
      else $error("result during sync hold");
   AST_RESULT_WIDTH: assert property (o_result_valid && i_short_result_width && $past(i_short_result_width)
      |-> o_result[23:16] == 8'h00) else $error("short result too wide");
   AST_DOUT_READ: assert property (i_read_active |=> o_dout_rdy_n == $past(i_read_bit))
      else $error("read bit not on data-out");
   AST_DOUT_HOLD: assert property (i_dout_reset && !i_cs_n && !i_read_active && $past(i_read_active)
      |=> $stable(o_dout_rdy_n)) else $error("read data not held");
endmodule

bind adc_aux_functions adc_aux_functions_chk adc_aux_functions_chk_inst (.*);

// ===== test/host_pin_model.sv
// host side of the aux pins and the shared sync pin
// assumes the bench calls sync_pulse to frame a sync cycle
`timescale 1ns/1ps
module host_pin_model (
   // clock
   input  wire logic       i_clk_sys,
   // levels the host drives when the device does not
   input  wire logic [1:0] i_aux_drive,
   // device pin drive
   input  wire logic [1:0] i_aux_out,
   input  wire logic [1:0] i_aux_oe,
   input  wire logic       i_fault_out,
   input  wire logic       i_fault_oe,
   // resolved pin levels
   output logic [1:0]      o_aux_pin,
   output logic            o_sync_pin
);
   logic sync_level = 1'b1;
   assign o_aux_pin  = (i_aux_oe & i_aux_out) | (~i_aux_oe & i_aux_drive);
   assign o_sync_pin = i_fault_oe ? i_fault_out : sync_level;

   task automatic sync_pulse(input int low_cycles);
      @(posedge i_clk_sys);
      #1 sync_level = 1'b0;
      repeat (low_cycles) @(posedge i_clk_sys);
      #1 sync_level = 1'b1;
   endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench for the auxiliary digital functions block
// assumes the checker is bound and the host model drives the pins
`timescale 1ns/1ps
module tb_top;
   logic        i_clk_sys, i_reset, i_aux0_input_enable, i_aux1_input_enable, i_aux0_output_enable;
   logic        i_aux1_output_enable, i_aux0_level_bit, i_aux1_level_bit, i_fault_pin_level, i_sync_select;
   logic        i_external_mux_timing, i_short_result_width, i_dout_reset, i_hide_delay, i_sinc_combined;
   logic        i_conv_start, i_crc_go, i_crc_use_xor, i_cs_n, i_read_active, i_read_bit, i_read_done;
   logic [15:0] i_converter_mode_control;
   logic [1:0]  i_fault_func, aux_drive, en_out, ien, lvl;
   logic [23:0] i_rate_sps, i_conv_cycles, i_raw_result;
   logic [31:0] i_crc_msg;
   logic [2:0]  i_crc_bytes;
   wire  [1:0]  i_aux_pin, o_aux_pin_out, o_aux_pin_oe, o_aux_level_read;
   wire         i_sync_fault_pin, o_sync_fault_out, o_sync_fault_oe, o_dout_rdy_n, o_filter_reset;
   wire         o_avg_trimmed, o_result_valid, o_checksum_valid;
   wire  [23:0] o_result;
   wire  [7:0]  o_checksum;
   int          fail_count = 0, tests_run = 0, seed = 32'h7ece, len, len0;
   logic [23:0] crc_q[$], res_q[$];
   int          dcode[10] = '{0, 3, 7, 1, 1, 1, 1, 1, 1, 3};
   int          hide[10]  = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 1};
   int          rate[10]  = '{1000, 1000, 1000, 1000, 3975, 599, 500, 167, 100000, 1000};
   int          extra[10] = '{0, 40, 1000, 0, 4, 4, 4, 4, 4, 40};

   adc_aux_functions #(.US_CYCLES(1)) adc_aux_functions_inst (.*);
   host_pin_model host_pin_model_inst (.i_clk_sys, .i_aux_drive(aux_drive), .i_aux_out(o_aux_pin_out),
      .i_aux_oe(o_aux_pin_oe), .i_fault_out(o_sync_fault_out), .i_fault_oe(o_sync_fault_oe),
      .o_aux_pin(i_aux_pin), .o_sync_pin(i_sync_fault_pin));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      fail_count++;
      end_of_test();
   end

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   function automatic logic [7:0] crc_of(input logic [31:0] m, input int n, input logic use_xor);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < n * 8; i++) c = use_xor ? c : {c[6:0], 1'b0} ^ ((c[7] ^ m[31 - i]) ? 8'h07 : 8'h00);
      for (int i = 0; i < n; i++) c = use_xor ? c ^ m[31 - 8 * i -: 8] : c;
      return c;
   endfunction
   task automatic crc_req(input logic [31:0] m, input int n, input logic x);
      {i_crc_msg, i_crc_bytes, i_crc_use_xor, i_crc_go} = {m, 3'(n), x, 1'b1};
      crc_q.push_back({16'h0000, crc_of(m, n, x)});
      tick(1);
   endtask
   task automatic wait_result(input int limit);
      len = 1;
      while (o_result_valid !== 1'b1 && len < limit) begin
         tick(1);
         len++;
      end
   endtask
   task automatic conv(input int code, input int hd, input int rt);
      i_converter_mode_control = {5'h00, 3'(code), 8'h00};
      {i_hide_delay, i_rate_sps, i_raw_result} = {1'(hd), 24'(rt), 24'($random(seed))};
      res_q.push_back(i_short_result_width ? (i_raw_result[23:8] == 16'hffff ? 24'h00_ffff :
         {8'h00, i_raw_result[23:8] + {15'h0000, i_raw_result[7]}}) : i_raw_result);
      i_conv_start = 1'b1;
      tick(1);
      i_conv_start = 1'b0;
      wait_result(3000);
      tick(2);
      check("ready low", o_dout_rdy_n, 24'h0);
   endtask

   always @(negedge i_clk_sys) begin
      if (o_checksum_valid === 1'b1) check("checksum", o_checksum, crc_q.size() ? crc_q.pop_front() : 'x);
      if (o_result_valid === 1'b1) check("result", o_result, res_q.size() ? res_q.pop_front() : 'x);
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {i_converter_mode_control, i_aux0_input_enable, i_aux1_input_enable, i_aux0_output_enable} = '0;
      {i_aux1_output_enable, i_aux0_level_bit, i_aux1_level_bit, i_fault_pin_level, i_sync_select} = '0;
      {i_external_mux_timing, i_short_result_width, i_dout_reset, i_hide_delay, i_conv_start, i_crc_go} = '0;
      {i_crc_use_xor, i_cs_n, i_read_active, i_read_bit, i_read_done, i_fault_func, aux_drive} = '0;
      {i_rate_sps, i_raw_result, i_crc_msg, i_crc_bytes} = '0;
      {i_reset, i_sinc_combined, i_conv_cycles} = {1'b1, 1'b1, 24'd20};
      tick(10);
      check("reset outputs", {o_result_valid, o_checksum_valid, o_filter_reset, o_dout_rdy_n}, 24'h1);
      i_reset = 1'b0;
      crc_req(32'h6543_2100, 3, 1'b0);
      crc_req(32'h6543_2100, 3, 1'b1);
      for (int k = 0; k < 16; k++) crc_req($random(seed), k % 4 + 1, k[0]);
      i_crc_go = 1'b0;
      tick(2);
      $display("test checksum done");
      for (int k = 0; k < 12; k++) begin
         {i_aux0_input_enable, i_aux1_input_enable, i_aux0_output_enable, i_aux1_output_enable} = 4'($random(seed));
         {i_aux0_level_bit, i_aux1_level_bit, aux_drive} = 4'($random(seed));
         tick(4);
         ien = {i_aux1_input_enable, i_aux0_input_enable};
         lvl = {i_aux1_level_bit, i_aux0_level_bit};
         en_out = {i_aux1_output_enable, i_aux0_output_enable} & ~ien;
         check("aux oe", o_aux_pin_oe, en_out);
         check("aux out", o_aux_pin_out & en_out, lvl & en_out);
         check("aux read", o_aux_level_read, (ien & aux_drive) | (~ien & lvl));
      end
      i_fault_func = 2'b11;
      for (int k = 0; k < 4; k++) begin
         i_fault_pin_level = k[0];
         tick(2);
         check("fault pin", {o_sync_fault_oe, o_sync_fault_out}, {23'h1, k[0]});
      end
      i_fault_func = 2'b00;
      $display("test pins done");
      for (int k = 0; k < 10; k++) begin
         i_short_result_width = k[0];
         conv(dcode[k], hide[k], rate[k]);
         if (k == 0) len0 = len;
         check("conv length", 24'(len), 24'(len0 + extra[k]));
         check("trimmed", o_avg_trimmed, 24'(k == 3));
      end
      $display("test conversion done");
      {i_aux0_input_enable, i_aux0_output_enable, i_aux0_level_bit} = 3'b010;
      tick(3);
      {i_external_mux_timing, i_aux0_level_bit} = 2'b11;
      tick(5);
      check("mux hold", o_aux_pin_out[0], 24'h0);
      conv(0, 0, 1000);
      check("mux update", o_aux_pin_out[0], 24'h1);
      $display("test mux done");
      for (int d = 0; d < 2; d++) begin
         i_dout_reset = d[0];
         i_read_active = 1'b1;
         for (int b = 0; b < 8; b++) begin
            i_read_bit = (b == 7) ? 1'b0 : 1'($random(seed));
            tick(1);
            check("read bit", o_dout_rdy_n, {23'h0, i_read_bit});
         end
         {i_read_active, i_read_done} = 2'b01;
         tick(1);
         i_read_done = 1'b0;
         tick(3);
         check("after read", o_dout_rdy_n, 24'(1 - d));
         i_cs_n = 1'b1;
         tick(2);
         check("cs high", o_dout_rdy_n, 24'h1);
         i_cs_n = 1'b0;
      end
      $display("test data-out done");
      {i_sync_select, i_short_result_width} = 2'b10;
      i_conv_start = 1'b1;
      tick(1);
      i_conv_start = 1'b0;
      tick(5);
      res_q.push_back(i_raw_result);
      fork
         host_pin_model_inst.sync_pulse(6);
      join_none
      tick(5);
      check("filter reset", o_filter_reset, 24'h1);
      wait_result(300);
      check("sync start", o_result_valid, 24'h1);
      tick(3);
      $display("test sync done");
      end_of_test();
   end
endmodule
